// >>> verilog/rtcv_params.svh
`ifndef RTCV_PARAMS_SVH
`define RTCV_PARAMS_SVH

`define RTCV_OFS_CONFIG        8'h00
`define RTCV_OFS_ALARM_CONFIG  8'h04
`define RTCV_OFS_TIME_UPPER    8'h08
`define RTCV_OFS_TIME_LOWER    8'h0c
`define RTCV_OFS_ALARM_UPPER   8'h10
`define RTCV_OFS_ALARM_LOWER   8'h14

`define RTCV_BIT_WRITE_ENABLE  13
`define RTCV_BIT_HALF_SECOND   11
`define RTCV_PTR_MSB           9
`define RTCV_PTR_LSB           8

`define RTCV_MASK_MIN_SEC      16'h7f7f
`define RTCV_MASK_WEEKDAY_HRS  16'h073f
`define RTCV_MASK_MONTH_DAY    16'h1f3f
`define RTCV_MASK_YEAR         16'h00ff
`define RTCV_MASK_NONE         16'h0000

`define RTCV_PTR_MIN_SEC       2'h0
`define RTCV_CONFIG_RESET      1'h0
`define RTCV_PTR_RESET         2'h0
`endif

// >>> verilog/rtcv_pkg.sv
package rtcv_pkg;
   typedef enum logic [2:0] {
      rtcv_bus_idle,
      rtcv_bus_write,
      rtcv_bus_read_mem,
      rtcv_bus_read_cap,
      rtcv_bus_read_out
   } rtcv_bus_state_t;

   typedef enum logic [2:0] {
      rtcv_tgt_none,
      rtcv_tgt_config,
      rtcv_tgt_alarm_config,
      rtcv_tgt_time_window,
      rtcv_tgt_alarm_window
   } rtcv_target_t;

   typedef logic [2:0] rtcv_slot_t;
endpackage

// >>> verilog/rtcv_window_pointer.sv
`timescale 1ns/1ps
`include "rtcv_params.svh"
module rtcv_window_pointer
   import rtcv_pkg::*;
(
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       load,
   input  wire logic [1:0] load_value,
   input  wire logic       step,
   output logic      [1:0] ptr
);
   logic [1:0] base;

   // a software load and a step on the same edge: step applies to the new value
   assign base = load ? load_value : ptr;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ptr <= `RTCV_PTR_RESET;
      end
      else if (step && (base != `RTCV_PTR_MIN_SEC))
      begin
         ptr <= base - 2'h1;
      end
      else
      begin
         ptr <= base;
      end
   end
endmodule // rtcv_window_pointer

// >>> verilog/rtcv_value_store.sv
`timescale 1ns/1ps
`include "rtcv_params.svh"
module rtcv_value_store
   import rtcv_pkg::*;
(
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       wr_en,
   input  wire logic       wr_upper,
   input  wire rtcv_slot_t wr_slot,
   input  wire logic [7:0] wr_byte,
   input  wire rtcv_slot_t rd_slot,
   output logic     [15:0] rd_data
);
   // slots 0-3 time, 4-7 alarm; low two bits are the window pointer
   logic [15:0] mem [0:7];
   logic [15:0] wmask;

   function automatic logic [15:0] slot_mask(input rtcv_slot_t slot);
      logic [15:0] m;
      m = `RTCV_MASK_NONE;
      case (slot[1:0])
         2'h0: m = `RTCV_MASK_MIN_SEC;
         2'h1: m = `RTCV_MASK_WEEKDAY_HRS;
         2'h2: m = `RTCV_MASK_MONTH_DAY;
         2'h3: m = slot[2] ? `RTCV_MASK_NONE : `RTCV_MASK_YEAR;
         default: m = `RTCV_MASK_NONE;
      endcase
      return m;
   endfunction

   assign wmask = slot_mask(wr_slot);

   // no reset on contents; software loads them before use
   always_ff @(posedge hclk)
   begin
      if (wr_en && wr_upper)
      begin
         mem[wr_slot][15:8] <= (mem[wr_slot][15:8] & ~wmask[15:8]) | (wr_byte & wmask[15:8]);
      end
      else if (wr_en)
      begin
         mem[wr_slot][7:0] <= (mem[wr_slot][7:0] & ~wmask[7:0]) | (wr_byte & wmask[7:0]);
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rd_data <= 16'h0000;
      end
      // alarm slots share the same masks, except slot 7, which is masked to zero
      else
      begin
         rd_data <= mem[rd_slot] & slot_mask(rd_slot);
      end
   end
endmodule // rtcv_value_store

// >>> verilog/rtcv_value_regs.sv
`timescale 1ns/1ps
`include "rtcv_params.svh"
module rtcv_value_regs
   import rtcv_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic      [31:0] hrdata,
   output logic             hresp,
   input  wire logic        second_half_start,
   input  wire logic        second_start,
   output logic             value_write_enable,
   output logic             half_second_status,
   output logic      [1:0]  time_window_pointer,
   output logic      [1:0]  alarm_window_pointer
);
   rtcv_bus_state_t state;
   rtcv_bus_state_t next_state;
   rtcv_target_t    addr_target;
   rtcv_target_t    target;
   rtcv_slot_t      slot;
   rtcv_slot_t      addr_slot;
   logic            addr_upper;
   logic            upper;
   logic            take;
   logic            in_write;
   logic            store_wr_en;
   logic            time_load;
   logic            alarm_load;
   logic            time_step;
   logic            alarm_step;
   logic            min_sec_lower_write;
   logic [15:0]     store_rd_data;
   logic [31:0]     next_rdata;

   // only the low byte decodes; upper address bits must be zero
   function automatic rtcv_target_t decode(input logic [31:0] addr);
      rtcv_target_t t;
      t = rtcv_tgt_none;
      if (addr[31:8] == 24'h000000)
      begin
         case (addr[7:0])
            `RTCV_OFS_CONFIG:       t = rtcv_tgt_config;
            `RTCV_OFS_ALARM_CONFIG: t = rtcv_tgt_alarm_config;
            `RTCV_OFS_TIME_UPPER:   t = rtcv_tgt_time_window;
            `RTCV_OFS_TIME_LOWER:   t = rtcv_tgt_time_window;
            `RTCV_OFS_ALARM_UPPER:  t = rtcv_tgt_alarm_window;
            `RTCV_OFS_ALARM_LOWER:  t = rtcv_tgt_alarm_window;
            default:                t = rtcv_tgt_none;
         endcase
      end
      return t;
   endfunction

   function automatic logic is_upper(input logic [31:0] addr);
      return (addr[7:0] == `RTCV_OFS_TIME_UPPER) || (addr[7:0] == `RTCV_OFS_ALARM_UPPER);
   endfunction

   // address phase: nonseq or seq with hready high; hsize is not decoded
   assign take        = hsel && hready && htrans[1];
   assign addr_target = decode(haddr);
   assign addr_upper  = is_upper(haddr);
   assign addr_slot   = (addr_target == rtcv_tgt_alarm_window) ? {1'b1, alarm_window_pointer}
                                                              : {1'b0, time_window_pointer};
   assign in_write    = (state == rtcv_bus_write);
   assign hresp       = 1'b0;

   // reads wait two cycles so a write in the previous data phase is seen
   assign hreadyout = (state != rtcv_bus_read_mem) && (state != rtcv_bus_read_cap);

   always_comb
   begin
      next_state = state;
      case (state)
         rtcv_bus_read_mem:
            next_state = rtcv_bus_read_cap;
         rtcv_bus_read_cap:
            next_state = rtcv_bus_read_out;
         rtcv_bus_idle, rtcv_bus_write, rtcv_bus_read_out:
         begin
            if (take && hwrite)
            begin
               next_state = rtcv_bus_write;
            end
            else if (take)
            begin
               next_state = rtcv_bus_read_mem;
            end
            else
            begin
               next_state = rtcv_bus_idle;
            end
         end
         default:
            next_state = rtcv_bus_idle;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state <= rtcv_bus_idle;
      end
      else
      begin
         state <= next_state;
      end
   end

   // pointer value is frozen into the slot when the address is taken
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         target <= rtcv_tgt_none;
         slot   <= 3'h0;
         upper  <= 1'b0;
      end
      else if (take)
      begin
         target <= addr_target;
         slot   <= addr_slot;
         upper  <= addr_upper;
      end
   end

   // every read or write of the upper time half steps the pointer down, holding at 0
   assign time_step  = take && (addr_target == rtcv_tgt_time_window) && addr_upper;
   // same for the upper alarm half
   assign alarm_step = take && (addr_target == rtcv_tgt_alarm_window) && addr_upper;
   assign time_load  = in_write && (target == rtcv_tgt_config);
   assign alarm_load = in_write && (target == rtcv_tgt_alarm_config);

   rtcv_window_pointer u_time_pointer (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .load       (time_load),
      .load_value (hwdata[`RTCV_PTR_MSB:`RTCV_PTR_LSB]),
      .step       (time_step),
      .ptr        (time_window_pointer)
   );

   rtcv_window_pointer u_alarm_pointer (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .load       (alarm_load),
      .load_value (hwdata[`RTCV_PTR_MSB:`RTCV_PTR_LSB]),
      .step       (alarm_step),
      .ptr        (alarm_window_pointer)
   );

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         value_write_enable <= `RTCV_CONFIG_RESET;
      end
      // enable bit lives at bit 13 of config
      else if (time_load)
      begin
         value_write_enable <= hwdata[`RTCV_BIT_WRITE_ENABLE];
      end
   end

   // window writes gated by the enable bit
   assign store_wr_en = in_write && value_write_enable
                        && ((target == rtcv_tgt_time_window) || (target == rtcv_tgt_alarm_window));

   // lower half of time minutes-seconds, only when the write lands
   assign min_sec_lower_write = store_wr_en && !upper && (slot == 3'h0);

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         half_second_status <= `RTCV_CONFIG_RESET;
      end
      // the engine's set wins over a software clear on the same edge
      else if (second_half_start)
      begin
         half_second_status <= 1'b1;
      end
      else if (min_sec_lower_write || second_start)
      begin
         half_second_status <= 1'b0;
      end
   end

   rtcv_value_store u_store (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .wr_en    (store_wr_en),
      .wr_upper (upper),
      .wr_slot  (slot),
      .wr_byte  (hwdata[7:0]),
      .rd_slot  (slot),
      .rd_data  (store_rd_data)
   );

   always_comb
   begin
      next_rdata = 32'h00000000;
      case (target)
         rtcv_tgt_config:
         begin
            next_rdata[`RTCV_BIT_WRITE_ENABLE]       = value_write_enable;
            next_rdata[`RTCV_BIT_HALF_SECOND]        = half_second_status;
            next_rdata[`RTCV_PTR_MSB:`RTCV_PTR_LSB]  = time_window_pointer;
         end
         rtcv_tgt_alarm_config:
            next_rdata[`RTCV_PTR_MSB:`RTCV_PTR_LSB]  = alarm_window_pointer;
         // unimplemented bits arrive as zero from the store
         rtcv_tgt_time_window, rtcv_tgt_alarm_window:
            next_rdata[7:0] = upper ? store_rd_data[15:8] : store_rd_data[7:0];
         default:
            next_rdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hrdata <= 32'h00000000;
      end
      else if (state == rtcv_bus_read_cap)
      begin
         hrdata <= next_rdata;
      end
   end
endmodule // rtcv_value_regs

// >>> tb/rtcv_value_regs_checker.sv
`timescale 1ns/1ps
module rtcv_value_regs_checker
(
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic        second_half_start,
   input wire logic        value_write_enable,
   input wire logic        half_second_status,
   input wire logic [1:0]  time_window_pointer,
   input wire logic [1:0]  alarm_window_pointer
);
   logic tk;
   logic cfg_land;
   assign tk = hsel && hready && htrans[1];
   // a config write landing rewrites the pointer itself
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         cfg_land <= 1'b0;
      else
         cfg_land <= tk && hwrite && (haddr[7:0] <= 8'h04);
   end
   default clocking dc @(posedge hclk); endclocking
   default disable iff (!hresetn);
   tptr_step_a: assert property (tk && haddr[7:0] == 8'h08 && !cfg_land |=>
      time_window_pointer == (($past(time_window_pointer) == 2'h0) ? 2'h0 : $past(time_window_pointer) - 2'h1))
      else $error("time pointer did not step down");
   aptr_step_a: assert property (tk && haddr[7:0] == 8'h10 && !cfg_land |=>
      alarm_window_pointer == (($past(alarm_window_pointer) == 2'h0) ? 2'h0 : $past(alarm_window_pointer) - 2'h1))
      else $error("alarm pointer did not step down");
   read_wait_a: assert property (tk && !hwrite |=> !hreadyout [*2] ##1 hreadyout)
      else $error("read wait states wrong");
   write_nowait_a: assert property (tk && hwrite |=> hreadyout)
      else $error("write inserted wait state");
   hsec_clear_a: assert property (tk && hwrite && haddr[7:0] == 8'h0c && time_window_pointer == 2'h0
      ##1 (value_write_enable && !second_half_start && time_window_pointer == 2'h0) |=> !half_second_status)
      else $error("half second not cleared");
   hsec_set_a: assert property (second_half_start |=> half_second_status)
      else $error("half second not set");
   wren_change_a: assert property ($changed(value_write_enable) |->
      $past(tk && hwrite && haddr[7:0] == 8'h00, 2))
      else $error("write enable changed without config write");
   zero_read_a: assert property (tk && !hwrite && ((haddr[7:0] == 8'h08 && time_window_pointer == 2'h3)
      || haddr[7:0] > 8'h14) |=> ##2 hrdata == 32'h0)
      else $error("reserved read not zero");
   cover property (tk && !hwrite && haddr[7:0] == 8'h08 && time_window_pointer == 2'h3);
   cover property (second_half_start);
   cover property ($fell(value_write_enable));
endmodule // rtcv_value_regs_checker

bind rtcv_value_regs rtcv_value_regs_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
   .second_half_start(second_half_start), .value_write_enable(value_write_enable),
   .half_second_status(half_second_status), .time_window_pointer(time_window_pointer),
   .alarm_window_pointer(alarm_window_pointer));

// >>> tb/rtcv_value_regs_tb.sv
`timescale 1ns/1ps
module rtcv_value_regs_tb;
   logic        hclk, hresetn, hwrite, half_start, sec_start, hreadyout, hresp, wren, hsec;
   logic [31:0] haddr, hwdata, hrdata, rdata;
   logic [1:0]  htrans, tptr, aptr;
   int          num_errors, n_compared;
   logic [7:0]  lo_m [4] = '{8'h7f, 8'h3f, 8'h3f, 8'hff};
   logic [7:0]  up_m [4] = '{8'h7f, 8'h07, 8'h1f, 8'h00};

   always #4 hclk = ~hclk;

   rtcv_value_regs u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .second_half_start(half_start), .second_start(sec_start),
      .value_write_enable(wren), .half_second_status(hsec), .time_window_pointer(tptr),
      .alarm_window_pointer(aptr));

   task results;
      if (num_errors == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rdata = hrdata;
   endtask

   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      n_compared++;
      if (s !== e)
      begin
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
         num_errors++;
      end
   endtask

   task cr(input logic [7:0] a, input logic [31:0] e);
      xfer(a, 1'b0, 32'h0);
      chk("read data", e, rdata);
   endtask

   // upper accesses step the pointer, so lower goes first in each pair
   task sweep(input logic w, input logic [7:0] d, input logic [15:0] cfg, input logic [7:0] e);
      logic [7:0] up;
      logic [7:0] k;
      up = w ? 8'h10 : 8'h08;
      for (int p = 0; p < 2; p++)
      begin
         xfer(8'h00, 1'b1, {16'h0, cfg});
         if (w)
            xfer(8'h04, 1'b1, 32'h300);
         for (int i = 3; i >= 0; i--)
         begin
            k = (w && i == 3) ? 8'h00 : 8'hff;
            if (p == 0)
            begin
               xfer(up + 8'h04, 1'b1, {24'h0, d});
               xfer(up, 1'b1, {24'h0, d});
            end
            else
            begin
               cr(up + 8'h04, {24'h0, e & lo_m[i] & k});
               cr(up, {24'h0, e & up_m[i] & k});
            end
         end
      end
      chk("pointer", 32'h0, {30'h0, w ? aptr : tptr});
   endtask

   task pulse(input logic s);
      if (s)
         sec_start <= 1'b1;
      else
         half_start <= 1'b1;
      @(posedge hclk);
      sec_start <= 1'b0;
      half_start <= 1'b0;
      @(posedge hclk);
   endtask

   initial
   begin
      #100000;
      num_errors++;
      results;
   end

   initial
   begin
      hclk = 0;
      hresetn = 0;
      haddr = 0;
      htrans = 0;
      hwrite = 0;
      hwdata = 0;
      half_start = 0;
      sec_start = 0;
      num_errors = 0;
      n_compared = 0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      cr(8'h00, 32'h0);
      chk("response", 32'h0, {31'h0, hresp});
      for (int w = 0; w < 2; w++)
      begin
         sweep(w[0], 8'hff, 16'h2300, 8'hff);
         sweep(w[0], 8'h00, 16'h0300, 8'hff);
         sweep(w[0], 8'h59, 16'h2300, 8'h59);
      end
      cr(8'h00, 32'h2300);
      pulse(1'b0);
      cr(8'h00, 32'h2b00);
      xfer(8'h00, 1'b1, 32'h0);
      xfer(8'h0c, 1'b1, 32'h0);
      cr(8'h00, 32'h0800);
      cr(8'h0c, 32'h59);
      xfer(8'h00, 1'b1, 32'h2000);
      xfer(8'h0c, 1'b1, 32'h12);
      cr(8'h00, 32'h2000);
      cr(8'h0c, 32'h12);
      xfer(8'h08, 1'b1, 32'h47);
      cr(8'h08, 32'h47);
      pulse(1'b0);
      pulse(1'b1);
      cr(8'h00, 32'h2000);
      // set and clear on one edge: the set must win
      half_start <= 1'b1;
      pulse(1'b1);
      cr(8'h00, 32'h2800);
      xfer(8'h04, 1'b1, 32'h0200);
      cr(8'h04, 32'h0200);
      cr(8'h10, 32'h19);
      cr(8'h04, 32'h0100);
      xfer(8'h20, 1'b1, 32'hffffffff);
      cr(8'h20, 32'h0);
      results;
   end
endmodule // rtcv_value_regs_tb
